// file: common/psc_pkg.sv
package psc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CORE_CTRL = 12'h000;
  localparam logic [11:0] OFS_PCLK_SET = 12'h004;
  localparam logic [11:0] OFS_PCLK_CLR = 12'h008;
  localparam logic [11:0] OFS_PCLK_STAT = 12'h00c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  // Core clock stop bit in the core control register
  localparam int CORE_STOP_BIT = 0;
  // Peripheral bits match the interrupt source numbers
  localparam int BIT_SERIAL0 = 2;
  localparam int BIT_SERIAL1 = 3;
  localparam int BIT_TIMER0 = 4;
  localparam int BIT_TIMER1 = 5;
  localparam int BIT_TIMER2 = 6;
  localparam int BIT_PARIO = 8;
  localparam logic [31:0] PCLK_MASK = 32'h0000017c;
  localparam logic [31:0] PCLK_RST = 32'h0000017c;
  localparam logic CORE_RST = 1'b1;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: hdl/psc_gate.sv
// Holds one clock-run flag; a start request wins over a stop request,
// so a wake event in the same cycle as a stop is never lost.
module psc_gate #(
  parameter logic RST_ON = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic on_req,
  input wire logic off_req,
  output logic run_r
);

  // Run flag, changes only at a clock edge or on async reset, so outside reset enables are whole cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r <= RST_ON;
    end else if (on_req) begin
      run_r <= 1'b1;
    end else if (off_req) begin
      // Stop takes effect at the next edge, no draining of the domain
      run_r <= 1'b0;
    end
  end

endmodule

// file: hdl/psc_top.sv
// Contract
// - Core clock runs after reset; any enabled interrupt or reset restarts it.
// - Writing one to control bit 0 stops core clock; zero does nothing.
// - Writing ones to enable register starts those peripheral clocks.
// - Writing ones to disable register stops those peripheral clocks.
// - Status register reads one for each running peripheral clock.
// - After reset all peripheral clocks run; status reads 0x17C.
// - A disable stops the peripheral clock at once, no waiting.
// - Restarted peripheral resumes from its held state; gating never resets.
// - Peripheral bit positions equal their interrupt source numbers.
//
// The AXI4-Lite register port was decided locally.
module psc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [psc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [psc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [psc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [psc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] irq_source,
  input wire logic [31:0] irq_enable,
  output logic core_clock_en,
  output logic serial_port0_clock_en,
  output logic serial_port1_clock_en,
  output logic timer_chan0_clock_en,
  output logic timer_chan1_clock_en,
  output logic timer_chan2_clock_en,
  output logic parallel_io_clock_en
);
  import psc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expand byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Word-aligned offset of a bus address
  function automatic logic [11:0] word_ofs(input logic [ADDR_W-1:0] a);
    return {a[11:2], 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] aw_ofs_r;
  logic [31:0] w_data_r;
  logic wr_commit;
  logic wr_mapped;
  logic core_stop;
  logic [31:0] pclk_set;
  logic [31:0] pclk_clr;
  logic wake;
  logic [31:0] pclk_run;

  assign wr_commit = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_mapped = (aw_ofs_r == OFS_CORE_CTRL) ||
                     (aw_ofs_r == OFS_PCLK_SET) ||
                     (aw_ofs_r == OFS_PCLK_CLR) ||
                     (aw_ofs_r == OFS_PCLK_STAT);

  // Address and data are taken in either order, one write at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      aw_ofs_r <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_ofs_r <= word_ofs(s_axi_awaddr);
      s_axi_awready <= 1'b0;
    end else if (wr_commit) begin
      aw_hold_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Data with byte strobes folded in, so unstrobed lanes act as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_hold_r <= 1'b0;
      w_data_r <= 32'h00000000;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata & strb_mask(s_axi_wstrb);
      s_axi_wready <= 1'b0;
    end else if (wr_commit) begin
      w_hold_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; the status register is read-only and ignores writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // core stop: only a one in bit 0 has effect
  assign core_stop = wr_commit && (aw_ofs_r == OFS_CORE_CTRL) &&
                     w_data_r[CORE_STOP_BIT];
  // set command: zero bits and unused positions are ignored
  assign pclk_set = (wr_commit && aw_ofs_r == OFS_PCLK_SET) ?
                    (w_data_r & PCLK_MASK) : 32'h00000000;
  // clear command: same positions as the set register
  assign pclk_clr = (wr_commit && aw_ofs_r == OFS_PCLK_CLR) ?
                    (w_data_r & PCLK_MASK) : 32'h00000000;
  // wake on any interrupt that is both pending and enabled
  assign wake = |(irq_source & irq_enable);

  // ----------------------------------------------------------------
  // Clock run flags
  // ----------------------------------------------------------------
  // core gate: wake wins over a stop written in the same cycle
  psc_gate #(
    .RST_ON(CORE_RST)
  ) u_core_gate (
    .clk(clk),
    .rst(rst),
    .on_req(wake),
    .off_req(core_stop),
    .run_r(core_clock_en)
  );

  // one gate per interrupt source number that owns a peripheral
  for (genvar g = 0; g < 32; g++) begin : g_pclk
    if (PCLK_MASK[g]) begin : g_on
      // stop applies at the very next edge, no handshake
      psc_gate #(
        .RST_ON(PCLK_RST[g])
      ) u_gate (
        .clk(clk),
        .rst(rst),
        .on_req(pclk_set[g]),
        .off_req(pclk_clr[g]),
        .run_r(pclk_run[g])
      );
    end else begin : g_off
      assign pclk_run[g] = 1'b0;
    end
  end

  // enables are flops; the domain's clock-enable keeps whole cycles
  assign serial_port0_clock_en = pclk_run[BIT_SERIAL0];
  assign serial_port1_clock_en = pclk_run[BIT_SERIAL1];
  assign timer_chan0_clock_en = pclk_run[BIT_TIMER0];
  assign timer_chan1_clock_en = pclk_run[BIT_TIMER1];
  assign timer_chan2_clock_en = pclk_run[BIT_TIMER2];
  assign parallel_io_clock_en = pclk_run[BIT_PARIO];

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [11:0] rd_ofs;

  assign rd_ofs = word_ofs(s_axi_araddr);

  // One read at a time; write-only registers read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      // status shows the live run flags
      case (rd_ofs)
        OFS_PCLK_STAT: s_axi_rdata <= pclk_run;
        OFS_CORE_CTRL, OFS_PCLK_SET, OFS_PCLK_CLR: begin
          s_axi_rdata <= 32'h00000000;
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic rst_seen_r;

  // Marks the first cycle after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
    end
  end

  reset_state_a: assert property (!rst_seen_r |->
    pclk_run == PCLK_RST && core_clock_en)
    else $error("clock flags wrong after reset");

  core_wake_a: assert property (!core_clock_en && wake |=>
    core_clock_en)
    else $error("core clock not restarted by interrupt");

  core_stop_a: assert property (core_stop && !wake |=>
    !core_clock_en)
    else $error("core clock not stopped");

  core_keep_a: assert property (!core_stop && !wake |=>
    $stable(core_clock_en))
    else $error("core clock changed without cause");

  pclk_set_a: assert property (|pclk_set |=>
    (pclk_run & $past(pclk_set)) == $past(pclk_set))
    else $error("peripheral clock not started");

  pclk_clr_a: assert property (|pclk_clr |=>
    (pclk_run & $past(pclk_clr)) == 32'h00000000)
    else $error("peripheral clock not stopped at once");

  pclk_hold_a: assert property (!(|pclk_set) && !(|pclk_clr) |=>
    $stable(pclk_run))
    else $error("peripheral clock changed without command");

  stat_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    rd_ofs == OFS_PCLK_STAT |=> s_axi_rvalid && s_axi_rdata ==
    $past(pclk_run))
    else $error("status read wrong");

  bit_map_a: assert property ((pclk_run & ~PCLK_MASK) == 32'h00000000
    && serial_port0_clock_en == pclk_run[2]
    && parallel_io_clock_en == pclk_run[8])
    else $error("peripheral bit map wrong");

  // write answer one cycle after both halves are held
  wr_resp_a: assert property (wr_commit |=> s_axi_bvalid ##0
    (s_axi_bresp == RESP_OKAY) == $past(wr_mapped))
    else $error("write response wrong");

  core_idle_c: cover property (core_stop ##1 !core_clock_en ##[1:20]
    core_clock_en);
  pclk_off_on_c: cover property (pclk_clr[BIT_TIMER0] ##[1:20]
    pclk_set[BIT_TIMER0]);
  stat_rd_c: cover property (s_axi_rvalid && s_axi_rready &&
    s_axi_rdata != PCLK_RST);
  bad_addr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule

// file: dv/psc_periph_model.sv
// Far side: one counter per gated peripheral domain
module psc_periph_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] en,
  output logic [5:0][7:0] cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] en_l;
  // glitch-free gate
  // Latch open only while clk is low, so no runt pulse escapes
  always_latch begin
    if (!clk) en_l = en;
  end
  for (genvar i = 0; i < 6; i++) begin : g_dom
    wire gclk = clk & en_l[i];
    logic [7:0] c_r;
    assign cnt[i] = c_r;
    // state kept
    // Only reset clears the state; a stopped clock merely freezes it
    always @(posedge gclk or posedge rst) begin
      if (rst) c_r <= 8'h00;
      else c_r <= c_r + 8'h01;
    end
  end
endmodule

// file: dv/test_power_saving_clock_gate.sv
module test_power_saving_clock_gate;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_clock_en;
  logic serial_port0_clock_en, serial_port1_clock_en;
  logic timer_chan0_clock_en, timer_chan1_clock_en;
  logic timer_chan2_clock_en, parallel_io_clock_en;
  logic [11:0] s_axi_awaddr, s_axi_araddr, a;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_wdata, s_axi_rdata, irq_source, irq_enable;
  logic [31:0] seed, exp_st, rd, t, d;
  logic [5:0] en;
  logic [5:0][7:0] cnt;
  int failures, compares;
  psc_top u_psc_top (.*);
  assign en = {parallel_io_clock_en, timer_chan2_clock_en,
    timer_chan1_clock_en, timer_chan0_clock_en,
    serial_port1_clock_en, serial_port0_clock_en};
  psc_periph_model u_psc_periph_model (.clk(clk), .rst(rst), .en(en),
    .cnt(cnt));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Enables placed at their status bit positions
  function automatic logic [31:0] obs();
    return {23'h0, en[5], 1'b0, en[4:0], 2'b00};
  endfunction
  function automatic logic [31:0] nxt_st(logic [31:0] s, logic [11:0] ad,
    logic [31:0] dt);
    if (ad == OFS_PCLK_SET) return s | (dt & PCLK_MASK);
    if (ad == OFS_PCLK_CLR) return s & ~(dt & PCLK_MASK);
    return s;
  endfunction
  task automatic report_and_stop();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Valids held until their own ready; response taken with bvalid
  task automatic wrr(logic [11:0] ad, logic [31:0] dt, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        return;
      end
    end
    failures++;
    report_and_stop();
  endtask
  task automatic rdr(logic [11:0] ad, output logic [31:0] v,
    output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        r = s_axi_rresp;
        return;
      end
    end
    failures++;
    report_and_stop();
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {irq_source, irq_enable} = '0;
    s_axi_wstrb = 4'hf;
    seed = 32'h07aa0693;
    failures = 0;
    compares = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("core_en", {31'h0, core_clock_en}, 32'h1);
    rdr(OFS_PCLK_STAT, rd, rs);
    chk("stat_rst", rd, PCLK_RST);
    exp_st = PCLK_RST;
    // Clear all, set all, then random set and clear traffic
    for (int i = 0; i < 40; i++) begin
      t = xs();
      a = (i == 0 || (i > 1 && t[0])) ? OFS_PCLK_CLR : OFS_PCLK_SET;
      d = (i < 2) ? 32'hffffffff : xs();
      wrr(a, d, rs);
      exp_st = nxt_st(exp_st, a, d);
      chk("enables", obs(), exp_st);
      rdr(OFS_PCLK_STAT, rd, rs);
      chk("stat", rd, exp_st);
    end
    // Stop timer 0 domain, then restart it; state must hold
    wrr(OFS_PCLK_CLR, 32'h10, rs);
    @(posedge clk);
    t = {24'h0, cnt[2]};
    repeat (8) @(posedge clk);
    chk("frozen", {24'h0, cnt[2]}, t);
    wrr(OFS_PCLK_SET, 32'h10, rs);
    repeat (4) @(posedge clk);
    d = {24'h0, cnt[2] - t[7:0]};
    chk("resumed", {31'h0, d > 0 && d < 8}, 32'h1);
    // Core clock stop and wake
    irq_source <= xs();
    wrr(OFS_CORE_CTRL, 32'h0, rs);
    chk("core_keep", {31'h0, core_clock_en}, 32'h1);
    wrr(OFS_CORE_CTRL, 32'h1, rs);
    chk("core_stop", {31'h0, core_clock_en}, 32'h0);
    repeat (5) @(posedge clk);
    chk("masked", {31'h0, core_clock_en}, 32'h0);
    irq_enable <= 32'h1 << t[4:0];
    irq_source <= 32'h1 << t[4:0];
    repeat (3) @(posedge clk);
    chk("wake", {31'h0, core_clock_en}, 32'h1);
    // Stop written while an enabled interrupt is still pending
    wrr(OFS_CORE_CTRL, 32'h1, rs);
    chk("wake_wins", {31'h0, core_clock_en}, 32'h1);
    irq_source <= 32'h0;
    wrr(OFS_CORE_CTRL, 32'h1, rs);
    wrr(OFS_PCLK_CLR, 32'h144, rs);
    // Reset in mid-run restarts everything
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("core_rst", {31'h0, core_clock_en}, 32'h1);
    chk("en_rst", obs(), PCLK_RST);
    // Access kinds and unmapped space
    wrr(OFS_PCLK_STAT, 32'h0, rs);
    chk("ro_bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
    rdr(OFS_PCLK_STAT, rd, rs);
    chk("ro_keep", rd, PCLK_RST);
    // Only byte lane 0 strobed: bit 8 of the clear word must not act
    s_axi_wstrb <= 4'h1;
    wrr(OFS_PCLK_CLR, 32'h144, rs);
    s_axi_wstrb <= 4'hf;
    chk("strobe", obs(), nxt_st(PCLK_RST, OFS_PCLK_CLR, 32'h44));
    rdr(OFS_PCLK_SET, rd, rs);
    chk("wo_read", rd, 32'h0);
    wrr(12'h010, 32'h17c, rs);
    chk("bad_bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    rdr(12'h010, rd, rs);
    chk("bad_rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    report_and_stop();
  end
endmodule
